// File: src/msd_axis_walk.sv
// Purpose: walks the set bits of an axis mask in ascending order
// Assumes: load and step never in the same cycle
// Notes: axis is the lowest bit still pending
`timescale 1ns/1ps
module msd_axis_walk #(
    parameter int N = 4
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    // control
    input wire logic load,
    input wire logic [N-1:0] mask,
    input wire logic step,
    // current axis
    output logic [2:0] axis,
    output logic last
);
    import msd_pkg::*;
    typedef struct packed {
        logic [N-1:0] rem;
    } msd_walk_st_t;
    msd_walk_st_t s_r, s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (load) begin
            s_nxt.rem = mask;
        end else if (step) begin
            s_nxt.rem = s_r.rem & (s_r.rem - N'(1)); // drop lowest bit
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign axis = msd_low_idx(8'(s_r.rem));
    assign last = (s_r.rem & (s_r.rem - N'(1))) == '0;
endmodule

// File: src/msd_core.sv
// Purpose: decodes setup command words and holds per-axis settings
// Assumes: words arrive code, mask, then arguments, synchronous to mclk
// Notes: notch path owns code 8Eh; low-pass is not built
`timescale 1ns/1ps
`include "msd_regs.svh"
module msd_core #(
    parameter int N = 4,
    parameter bit LARGE_MAP = 1'b0
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    // command words from shared host memory
    input wire logic cmd_valid,
    input wire logic [15:0] cmd_word,
    output logic cmd_ready,
    output logic cmd_reject,
    // servo side
    input wire logic [N-1:0] drive_block_active,
    input wire logic offset_done,
    input wire logic [15:0] offset_meas,
    output logic offset_start,
    output logic [N-1:0] offset_axis_bits,
    // per-axis settings
    output logic [N-1:0][15:0] accel_limit,
    output logic [N-1:0][15:0] motor_param,
    output logic [N-1:0] induction_motor_sel,
    output logic [N-1:0] electronically_commutated_sel,
    output logic [N-1:0][15:0] notch_freq,
    output logic [N-1:0][1:0] notch_q,
    output logic [N-1:0] notch_en,
    output logic [N-1:0][2:0] out_gain_shift,
    output logic [N-1:0][15:0] dac_offset,
    // shared memory status writes
    output logic smem_we,
    output logic [12:0] smem_addr,
    output logic [7:0] smem_wdata,
    output logic host_irq
);
    import msd_pkg::*;

    localparam int IW = $clog2(N);

    // three-bit axis index and the mask walk limit the axis count
    if (N < 2 || N > 8) begin : g_bad_axis_count
        $error("axis count must be 2 to 8");
    end

    typedef struct packed {
        msd_state_t st;
        logic [7:0] code;
        logic [N-1:0] mask;
        logic [15:0] freq;
        logic [IW-1:0] oaxis;
        logic rdy;
        logic ostart;
        logic rej;
        logic [N-1:0][15:0] acc;
        logic [N-1:0][15:0] mpar;
        logic [N-1:0][15:0] nfreq;
        logic [N-1:0][15:0] doff;
        logic [N-1:0][1:0] nq;
        logic [N-1:0][2:0] gsh;
        logic [N-1:0] ind;
        logic [N-1:0] ec;
        logic [N-1:0] nen;
        logic [N-1:0] obits;
    } msd_core_st_t;

    msd_core_st_t s_r, s_nxt;
    logic take;
    logic walk_load;
    logic walk_step;
    logic [2:0] wax;
    logic wlast;
    logic stat_start;
    logic [IW-1:0] a;
    logic known;

    // a word is taken only on an enabled cycle while ready
    assign take = cmd_valid && s_r.rdy && ce;
    assign a = wax[IW-1:0];
    assign known = (cmd_word[7:0] == `MSD_CMD_ACCEL) || (cmd_word[7:0] == `MSD_CMD_MPAR) ||
        (cmd_word[7:0] == `MSD_CMD_MTYPE) || (cmd_word[7:0] == `MSD_CMD_FILT) ||
        (cmd_word[7:0] == `MSD_CMD_OFFS) || (cmd_word[7:0] == `MSD_CMD_GAIN);

    msd_axis_walk #(.N(N)) u_walk (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .load(walk_load),
        .mask(cmd_word[N-1:0]),
        .step(walk_step),
        .axis(wax),
        .last(wlast)
    );

    msd_status_wr #(.LARGE_MAP(LARGE_MAP)) u_stat (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .start(stat_start),
        .axis(3'(s_r.oaxis)),
        .smem_we(smem_we),
        .smem_addr(smem_addr),
        .smem_wdata(smem_wdata),
        .host_irq(host_irq)
    );

    // command decode and parameter update
    always_comb begin
        s_nxt = s_r;
        s_nxt.ostart = 1'b0;
        s_nxt.rej = 1'b0;
        walk_load = 1'b0;
        walk_step = 1'b0;
        stat_start = 1'b0;
        case (s_r.st)
            MSD_S_IDLE: begin
                if (take) begin
                    s_nxt.code = cmd_word[7:0];
                    if (known) begin
                        s_nxt.st = MSD_S_MASK;
                    end else begin
                        s_nxt.rej = 1'b1;
                    end
                end
            end
            MSD_S_MASK: begin
                if (take) begin
                    s_nxt.mask = cmd_word[N-1:0];
                    walk_load = 1'b1;
                    if (s_r.code == `MSD_CMD_FILT) begin
                        s_nxt.st = MSD_S_NFREQ;
                    end else if (s_r.code == `MSD_CMD_OFFS) begin
                        if (msd_one_hot(8'(cmd_word[N-1:0]))) begin
                            s_nxt.oaxis = IW'(msd_low_idx(8'(cmd_word[N-1:0])));
                            s_nxt.obits[IW'(msd_low_idx(8'(cmd_word[N-1:0])))] = 1'b0;
                            s_nxt.ostart = 1'b1;
                            s_nxt.rdy = 1'b0;
                            s_nxt.st = MSD_S_OFFS;
                        end else begin
                            s_nxt.rej = 1'b1;
                            s_nxt.st = MSD_S_IDLE;
                        end
                    end else if (cmd_word[N-1:0] == '0) begin
                        s_nxt.st = MSD_S_IDLE; // empty mask carries no arguments
                    end else begin
                        s_nxt.st = MSD_S_ARGS;
                    end
                end
            end
            MSD_S_ARGS: begin
                if (take) begin
                    walk_step = 1'b1;
                    if (wlast) begin
                        s_nxt.st = MSD_S_IDLE;
                    end
                    case (s_r.code)
                        `MSD_CMD_ACCEL: begin
                            if (cmd_word != 16'h0000) begin
                                s_nxt.acc[a] = cmd_word;
                            end
                        end
                        `MSD_CMD_MPAR: begin
                            s_nxt.mpar[a] = cmd_word;
                        end
                        `MSD_CMD_MTYPE: begin
                            if (drive_block_active[a] || cmd_word > `MSD_TYPE_MAX) begin
                                s_nxt.rej = 1'b1;
                            end else begin
                                s_nxt.ind[a] = cmd_word == 16'h0001;
                                s_nxt.ec[a] = cmd_word == 16'h0002;
                            end
                        end
                        `MSD_CMD_GAIN: begin
                            if (cmd_word > `MSD_GAIN_MAX) begin
                                s_nxt.rej = 1'b1;
                            end else begin
                                s_nxt.gsh[a] = cmd_word[2:0];
                            end
                        end
                        default: begin
                            s_nxt.rej = 1'b1;
                        end
                    endcase
                end
            end
            MSD_S_NFREQ: begin
                if (take) begin
                    s_nxt.freq = cmd_word;
                    s_nxt.st = MSD_S_NQ;
                end
            end
            MSD_S_NQ: begin
                if (take) begin
                    s_nxt.st = MSD_S_IDLE;
                    if (msd_one_hot(8'(s_r.mask)) && s_r.freq <= `MSD_NOTCH_FMAX &&
                        (cmd_word == 16'h0001 || cmd_word == 16'h0002)) begin
                        s_nxt.nfreq[a] = s_r.freq;
                        s_nxt.nq[a] = cmd_word[1:0];
                        s_nxt.nen[a] = s_r.freq != 16'h0000;
                    end else begin
                        s_nxt.rej = 1'b1;
                    end
                end
            end
            MSD_S_OFFS: begin
                // wait for the servo to report tuning done
                if (offset_done && ce) begin
                    s_nxt.doff[s_r.oaxis] = offset_meas;
                    s_nxt.obits[s_r.oaxis] = 1'b1;
                    stat_start = 1'b1;
                    s_nxt.rdy = 1'b1;
                    s_nxt.st = MSD_S_IDLE;
                end
            end
            default: begin
                s_nxt.st = MSD_S_IDLE;
            end
        endcase
    end

    // reset leaves every notch off; ce low freezes all
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
            s_r.rdy <= 1'b1;
            s_r.st <= MSD_S_IDLE;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    // settings go straight to the servo
    assign cmd_ready = s_r.rdy;
    assign cmd_reject = s_r.rej;
    assign offset_start = s_r.ostart;
    assign offset_axis_bits = s_r.obits;
    assign accel_limit = s_r.acc;
    assign motor_param = s_r.mpar;
    assign induction_motor_sel = s_r.ind;
    assign electronically_commutated_sel = s_r.ec;
    assign notch_freq = s_r.nfreq;
    assign notch_q = s_r.nq;
    assign notch_en = s_r.nen;
    assign out_gain_shift = s_r.gsh;
    assign dac_offset = s_r.doff;

    // checks on decoded behaviour
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    logic [N-1:0] nz_h;
    logic gain_ok_h;
    always_comb begin
        gain_ok_h = 1'b1;
        for (int i = 0; i < N; i++) begin
            nz_h[i] = s_r.nfreq[i] != 16'h0000;
            if (s_r.gsh[i] > 3'h4) begin
                gain_ok_h = 1'b0;
            end
        end
    end

    a_accel_store: assert property (
        (take && s_r.st == MSD_S_ARGS && s_r.code == `MSD_CMD_ACCEL && cmd_word != 16'h0000)
        |=> s_r.acc[$past(a)] == $past(cmd_word))
        else $error("acceleration limit not stored");
    a_accel_zero: assert property (
        (take && s_r.st == MSD_S_ARGS && s_r.code == `MSD_CMD_ACCEL && cmd_word == 16'h0000)
        |=> $stable(s_r.acc))
        else $error("zero acceleration changed a limit");
    a_type_block: assert property (
        (take && s_r.st == MSD_S_ARGS && s_r.code == `MSD_CMD_MTYPE && drive_block_active[a])
        |=> $stable(s_r.ind) && $stable(s_r.ec) && cmd_reject)
        else $error("motor type changed under drive block");
    a_notch_enable: assert property (
        notch_en == nz_h)
        else $error("notch enable disagrees with frequency");
    a_gain_range: assert property (
        gain_ok_h)
        else $error("gain code above four stored");
    a_unknown_code: assert property (
        (take && s_r.st == MSD_S_IDLE && !known)
        |=> s_r.st == MSD_S_IDLE && cmd_reject)
        else $error("unknown code not dropped");
    a_offs_others: assert property (
        (s_r.st == MSD_S_OFFS && !offset_done) |=> $stable(s_r.obits) && $stable(s_r.doff))
        else $error("idle offset wait disturbed axes");
    a_offs_bits: assert property (
        stat_start |=> s_r.obits[$past(s_r.oaxis)] && s_r.doff[$past(s_r.oaxis)] == $past(offset_meas))
        else $error("offset completion not recorded");
    a_offs_post: assert property (
        stat_start |-> ##[1:16] (smem_we && smem_wdata[6] && host_irq))
        else $error("top status flag not written");
    // per-command storage and refusal
    a_mpar_store: assert property (
        (take && s_r.st == MSD_S_ARGS && s_r.code == `MSD_CMD_MPAR)
        |=> s_r.mpar[$past(a)] == $past(cmd_word))
        else $error("motor parameter not stored");
    a_type_store: assert property (
        (take && s_r.st == MSD_S_ARGS && s_r.code == `MSD_CMD_MTYPE && !drive_block_active[a] &&
            cmd_word <= `MSD_TYPE_MAX)
        |=> s_r.ind[$past(a)] == ($past(cmd_word) == 16'h0001) &&
            s_r.ec[$past(a)] == ($past(cmd_word) == 16'h0002))
        else $error("motor type not recorded");
    a_gain_store: assert property (
        (take && s_r.st == MSD_S_ARGS && s_r.code == `MSD_CMD_GAIN && cmd_word <= `MSD_GAIN_MAX)
        |=> s_r.gsh[$past(a)] == $past(cmd_word[2:0]))
        else $error("gain code not stored");
    a_gain_refuse: assert property (
        (take && s_r.st == MSD_S_ARGS && s_r.code == `MSD_CMD_GAIN && cmd_word > `MSD_GAIN_MAX)
        |=> $stable(s_r.gsh) && cmd_reject)
        else $error("gain code above four not refused");
    a_notch_store: assert property (
        (take && s_r.st == MSD_S_NQ && msd_one_hot(8'(s_r.mask)) && s_r.freq <= `MSD_NOTCH_FMAX &&
            (cmd_word == 16'h0001 || cmd_word == 16'h0002))
        |=> s_r.nfreq[$past(a)] == $past(s_r.freq) && s_r.nq[$past(a)] == $past(cmd_word[1:0]))
        else $error("notch setting not stored");
    a_notch_refuse: assert property (
        (take && s_r.st == MSD_S_NQ && s_r.freq > `MSD_NOTCH_FMAX)
        |=> $stable(s_r.nfreq) && $stable(s_r.nen) && cmd_reject)
        else $error("notch frequency above range not refused");
    a_offs_start: assert property (
        (take && s_r.st == MSD_S_MASK && s_r.code == `MSD_CMD_OFFS && msd_one_hot(8'(cmd_word[N-1:0])))
        |=> offset_start && !cmd_ready && $stable(s_r.doff))
        else $error("offset tuning not started");
    a_irq_addr: assert property (
        host_irq |-> smem_we && smem_addr == (LARGE_MAP ? `MSD_ADDR_TOP_L : `MSD_ADDR_TOP_S))
        else $error("interrupt not paired with top flag write");

    c_accel: cover property (take && s_r.st == MSD_S_ARGS && s_r.code == `MSD_CMD_ACCEL && wlast);
    c_notch: cover property (take && s_r.st == MSD_S_NQ && !cmd_reject);
    c_offset: cover property (host_irq);
    c_type_block: cover property (take && s_r.code == `MSD_CMD_MTYPE && drive_block_active[a]);
    c_offs_start: cover property (offset_start);
endmodule

// File: src/msd_pkg.sv
// Purpose: shared types and helpers of the setup command decoder
// Assumes: at most eight axes
// Notes: motor type argument 0 brush, 1 induction, 2 brushless
package msd_pkg;
    typedef enum logic [2:0] {
        MSD_S_IDLE = 3'h0,
        MSD_S_MASK = 3'h1,
        MSD_S_ARGS = 3'h2,
        MSD_S_NFREQ = 3'h3,
        MSD_S_NQ = 3'h4,
        MSD_S_OFFS = 3'h5
    } msd_state_t;

    // index of the lowest set bit, zero for an empty mask
    function automatic logic [2:0] msd_low_idx(input logic [7:0] m);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (m[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction

    // exactly one bit set
    function automatic logic msd_one_hot(input logic [7:0] m);
        return (m != 8'h00) && ((m & (m - 8'h01)) == 8'h00);
    endfunction
endpackage

// File: src/msd_regs.svh
// Purpose: constants of the motion setup command decoder
// Assumes: 16-bit command words, 8-bit shared memory data
// Notes: codes, limits, status locations and reset values
// Functional notes
// - code 71h stores per-axis acceleration limit
// - acceleration held as unsigned 1.15 value
// - zero acceleration argument keeps previous limit
// - stored limit feeds stop and velocity ramp
// - code 76h stores signed 16-bit motor parameter
// - parameter means slip gain or commutation angle
// - code 7Ch records brush, induction or brushless
// - motor type refused while drive block active
// - notch and low-pass share code 8Eh; only the notch is built
// - notch acts on one axis, 0-1650 Hz
// - quality 1 wide, 2 narrow notch
// - notch frequency zero disables the notch
// - every notch disabled after reset
// - code 5Fh offsets one axis, others untouched
// - completion raises interrupt, writes status host_interrupt_status
// - completion writes responsible axis to interrupt_axis_identity
// - completion sets bit 6 of top location
// - completion mirrored per axis in bits 0-3; the top location is written with bit 6 only
// - measured offset kept and subtracted afterwards; the code only holds it on dac_offset
// - code 81h gain code 0-4, default 0
// - mask bit k is axis k+1, ascending arguments
`ifndef MSD_REGS_SVH
`define MSD_REGS_SVH
`define MSD_CMD_ACCEL 8'h71
`define MSD_CMD_MPAR 8'h76
`define MSD_CMD_MTYPE 8'h7C
`define MSD_CMD_FILT 8'h8E
`define MSD_CMD_OFFS 8'h5F
`define MSD_CMD_GAIN 8'h81
`define MSD_NOTCH_FMAX 16'h0672
`define MSD_GAIN_MAX 16'h0004
`define MSD_TYPE_MAX 16'h0002
`define MSD_ADDR_INTSTAT 13'h0009
`define MSD_ADDR_AXISID 13'h000C
`define MSD_ADDR_TOP_S 13'h07FE
`define MSD_ADDR_TOP_L 13'h1FFE
`define MSD_TOP_OFFS_BIT 3'h6
`define MSD_INT_OFFS_CODE 8'h05
`define MSD_RST_WORD 16'h0000
`define MSD_RST_GAIN 3'h0
`endif

// File: src/msd_status_wr.sv
// Purpose: posts offset completion into shared host memory
// Assumes: start is a one-cycle pulse, not repeated while busy
// Notes: three writes on consecutive enabled cycles, irq with last
`timescale 1ns/1ps
`include "msd_regs.svh"
module msd_status_wr #(
    parameter bit LARGE_MAP = 1'b0
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    // trigger
    input wire logic start,
    input wire logic [2:0] axis,
    // shared memory write port
    output logic smem_we,
    output logic [12:0] smem_addr,
    output logic [7:0] smem_wdata,
    output logic host_irq
);
    import msd_pkg::*;
    typedef struct packed {
        logic [1:0] ph;
        logic [7:0] top;
        logic [7:0] id;
        logic we;
        logic [12:0] addr;
        logic [7:0] data;
        logic irq;
    } msd_sw_st_t;
    msd_sw_st_t s_r, s_nxt;

    // sequence: status code, axis identity, top flags
    always_comb begin
        s_nxt = s_r;
        s_nxt.we = 1'b0;
        s_nxt.irq = 1'b0;
        case (s_r.ph)
            2'h0: begin
                if (start) begin
                    s_nxt.id = 8'(axis) + 8'h01; // axis k reported as k+1
                    s_nxt.ph = 2'h1;
                end
            end
            2'h1: begin
                s_nxt.we = 1'b1;
                s_nxt.addr = `MSD_ADDR_INTSTAT;
                s_nxt.data = `MSD_INT_OFFS_CODE;
                s_nxt.ph = 2'h2;
            end
            2'h2: begin
                s_nxt.we = 1'b1;
                s_nxt.addr = `MSD_ADDR_AXISID;
                s_nxt.data = s_r.id;
                s_nxt.ph = 2'h3;
            end
            default: begin
                s_nxt.top[`MSD_TOP_OFFS_BIT] = 1'b1;
                s_nxt.we = 1'b1;
                s_nxt.addr = LARGE_MAP ? `MSD_ADDR_TOP_L : `MSD_ADDR_TOP_S;
                s_nxt.data = s_nxt.top;
                s_nxt.irq = 1'b1;
                s_nxt.ph = 2'h0;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign smem_we = s_r.we;
    assign smem_addr = s_r.addr;
    assign smem_wdata = s_r.data;
    assign host_irq = s_r.irq;
endmodule

// File: tb/msd_core_tb.sv
// Purpose: self-checking bench of the setup command decoder
// Assumes: four axes, small shared memory map
// Notes: inputs change on the falling edge only
`timescale 1ns/1ps
module msd_core_tb;
    logic mclk, rst, ce, cmd_valid, cmd_ready, cmd_reject, offset_done, offset_start;
    logic smem_we, host_irq;
    logic [15:0] cmd_word, offset_meas;
    logic [12:0] smem_addr;
    logic [7:0] smem_wdata, int_stat, axis_id, top_flags, irq_cnt;
    logic [3:0] drive_block_active, offset_axis_bits, ind_sel, ec_sel, notch_en;
    logic [3:0][15:0] accel_limit, motor_param, notch_freq, dac_offset;
    logic [3:0][1:0] notch_q;
    logic [3:0][2:0] out_gain_shift;
    int n_fail, num_checks, n_rej, er;

    msd_core #(.N(4), .LARGE_MAP(1'b0)) i_dut (.mclk(mclk), .rst(rst), .ce(ce),
        .cmd_valid(cmd_valid), .cmd_word(cmd_word), .cmd_ready(cmd_ready), .cmd_reject(cmd_reject),
        .drive_block_active(drive_block_active), .offset_done(offset_done), .offset_meas(offset_meas),
        .offset_start(offset_start), .offset_axis_bits(offset_axis_bits), .accel_limit(accel_limit),
        .motor_param(motor_param), .induction_motor_sel(ind_sel), .electronically_commutated_sel(ec_sel),
        .notch_freq(notch_freq), .notch_q(notch_q), .notch_en(notch_en), .out_gain_shift(out_gain_shift),
        .dac_offset(dac_offset), .smem_we(smem_we), .smem_addr(smem_addr), .smem_wdata(smem_wdata),
        .host_irq(host_irq));
    msd_host_mem i_host (.mclk(mclk), .rst(rst), .smem_we(smem_we), .smem_addr(smem_addr),
        .smem_wdata(smem_wdata), .host_irq(host_irq), .int_stat_r(int_stat), .axis_id_r(axis_id),
        .top_flags_r(top_flags), .irq_cnt_r(irq_cnt));

    // 100 MHz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // refusal pulses are counted so mid-command rejects are not missed
    always @(negedge mclk) begin
        if (cmd_reject === 1'b1) begin
            n_rej++;
        end
    end

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one word, presented once ready is high and held for one rising edge
    task automatic send(input logic [15:0] w);
        int k;
        k = 0;
        while (cmd_ready !== 1'b1 && k < 100) begin
            k++;
            @(negedge mclk);
        end
        cmd_valid = 1'b1;
        cmd_word = w;
        @(negedge mclk);
    endtask

    // a whole command, then one idle cycle so a late reject is counted
    task automatic run(input logic [15:0] ws[$]);
        foreach (ws[i]) begin
            send(ws[i]);
        end
        cmd_valid = 1'b0;
        cmd_word = 16'hA5A5;
        @(negedge mclk);
    endtask

    task automatic print_verdict();
        if (n_fail == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // watchdog well beyond the hundred or so cycles the tests need
    initial begin
        repeat (5000) @(posedge mclk);
        n_fail++;
        print_verdict();
    end

    initial begin
        ce = 1'b1;
        rst = 1'b1;
        cmd_valid = 1'b0;
        cmd_word = 16'h0000;
        drive_block_active = 4'h0;
        offset_done = 1'b0;
        offset_meas = 16'h0000;
        er = 0;
        repeat (4) @(negedge mclk);
        rst = 1'b0;
        chk("notch_en", 16'(notch_en), 16'h0000);
        chk("gain", 16'(out_gain_shift), 16'h0000);
        // acceleration: two axes, then a zero argument that must be ignored
        run('{16'h0071, 16'h0006, 16'h2000, 16'h2000});
        chk("acc1", accel_limit[1], 16'h2000);
        chk("acc0", accel_limit[0], 16'h0000);
        run('{16'h0071, 16'h0006, 16'h0000, 16'hFFFF});
        chk("acc1", accel_limit[1], 16'h2000);
        chk("acc2", accel_limit[2], 16'hFFFF);
        // motor parameter, signed extremes
        run('{16'h0076, 16'h000E, 16'h157C, 16'h8000, 16'h7FFF});
        chk("mpar2", motor_param[2], 16'h8000);
        chk("mpar3", motor_param[3], 16'h7FFF);
        // motor technology: all three types, then blocked and bad value
        run('{16'h007C, 16'h000B, 16'h0002, 16'h0000, 16'h0001});
        chk("ec_sel", 16'(ec_sel), 16'h0001);
        chk("ind_sel", 16'(ind_sel), 16'h0008);
        drive_block_active = 4'h8;
        run('{16'h007C, 16'h0008, 16'h0000});
        er++;
        chk("ind_sel", 16'(ind_sel), 16'h0008);
        drive_block_active = 4'h0;
        run('{16'h007C, 16'h0002, 16'h0003});
        er++;
        chk("ec_sel", 16'(ec_sel), 16'h0001);
        // notch: program, boundary, disable, then three refusals
        run('{16'h008E, 16'h0002, 16'h02EE, 16'h0002});
        chk("nfreq1", notch_freq[1], 16'h02EE);
        chk("nq1", 16'(notch_q[1]), 16'h0002);
        run('{16'h008E, 16'h0001, 16'h0672, 16'h0001});
        chk("nq0", 16'(notch_q[0]), 16'h0001);
        chk("notch_en", 16'(notch_en), 16'h0003);
        run('{16'h008E, 16'h0002, 16'h0000, 16'h0001});
        chk("notch_en", 16'(notch_en), 16'h0001);
        run('{16'h008E, 16'h0004, 16'h0673, 16'h0001});
        run('{16'h008E, 16'h0003, 16'h0064, 16'h0001});
        run('{16'h008E, 16'h0004, 16'h0064, 16'h0003});
        er += 3;
        chk("notch_en", 16'(notch_en), 16'h0001);
        // output gain: boundary code, two axes, then out of range and an unknown code
        run('{16'h0081, 16'h000C, 16'h0003, 16'h0001});
        run('{16'h0081, 16'h0001, 16'h0004});
        chk("gain", 16'(out_gain_shift), 16'h02C4);
        run('{16'h0081, 16'h0001, 16'h0005});
        run('{16'h0055});
        er += 2;
        chk("gain0", 16'(out_gain_shift[0]), 16'h0004);
        // ce low freezes the decoder: a whole gain command goes unseen
        ce = 1'b0;
        run('{16'h0081, 16'h0001, 16'h0000});
        ce = 1'b1;
        chk("gain0", 16'(out_gain_shift[0]), 16'h0004);
        chk("acc2", accel_limit[2], 16'hFFFF);
        chk("rejects", n_rej[15:0], er[15:0]);
        // tune axis 3 only with loop closed and still
        send(16'h005F);
        send(16'h0004);
        chk("offs_start", 16'(offset_start), 16'h0001);
        cmd_valid = 1'b0;
        repeat (3) @(negedge mclk);
        chk("ready", 16'(cmd_ready), 16'h0000);
        offset_meas = 16'h0123;
        offset_done = 1'b1;
        @(negedge mclk);
        offset_done = 1'b0;
        offset_meas = 16'hFEDC;
        repeat (6) @(negedge mclk);
        chk("dac2", dac_offset[2], 16'h0123);
        chk("dac0", dac_offset[0], 16'h0000);
        chk("offs_bits", 16'(offset_axis_bits), 16'h0004);
        chk("int_stat", 16'(int_stat), 16'h0005);
        chk("irq_cnt", 16'(irq_cnt), 16'h0001);
        chk("axis_id", 16'(axis_id), 16'h0003);
        chk("top_bit6", 16'(top_flags[6]), 16'h0001);
        chk("ready", 16'(cmd_ready), 16'h0001);
        print_verdict();
    end
endmodule

// File: tb/msd_host_mem.sv
// Purpose: host side of the shared memory, keeps the status bytes
// Assumes: one byte-wide write port, small map only
// Notes: other addresses are dropped; irq pulses are counted
`timescale 1ns/1ps
`include "msd_regs.svh"
module msd_host_mem (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // write port from the decoder
    input wire logic smem_we,
    input wire logic [12:0] smem_addr,
    input wire logic [7:0] smem_wdata,
    input wire logic host_irq,
    // stored status
    output logic [7:0] int_stat_r,
    output logic [7:0] axis_id_r,
    output logic [7:0] top_flags_r,
    output logic [7:0] irq_cnt_r
);
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            int_stat_r <= 8'h00;
            axis_id_r <= 8'h00;
            top_flags_r <= 8'h00;
            irq_cnt_r <= 8'h00;
        end else begin
            if (smem_we && smem_addr == `MSD_ADDR_INTSTAT) begin
                int_stat_r <= smem_wdata;
            end
            if (smem_we && smem_addr == `MSD_ADDR_AXISID) begin
                axis_id_r <= smem_wdata;
            end
            if (smem_we && smem_addr == `MSD_ADDR_TOP_S) begin
                top_flags_r <= smem_wdata;
            end
            // counted, not latched, so a repeated pulse shows up
            if (host_irq) begin
                irq_cnt_r <= irq_cnt_r + 8'h01;
            end
        end
    end
endmodule
